/* rtl/temp_sched_pkg.sv */
/*
  Constants and types for the conversion scheduler and result filter.
  Assumes a 100 MHz system clock and an APB register port with 32-bit data.
*/
package temp_sched_pkg;

  // register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_RATE = 12'h004;
  localparam logic [11:0] ADDR_FILTER = 12'h008;
  localparam logic [11:0] ADDR_ONESHOT = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_RESULT_BASE = 12'h014;
  localparam logic [11:0] ADDR_LIMIT_BASE = 12'h020;
  localparam logic [11:0] REG_STRIDE = 12'h004;

  // configuration bit positions
  localparam int CFG_STANDBY = 0;
  localparam int CFG_DYNAVG_OFF = 1;
  localparam int CFG_PAIRED1 = 2;
  localparam int CFG_PAIRED2 = 3;
  localparam logic [3:0] CONFIG_RESET = 4'h0;

  // conversion rate codes
  localparam logic [3:0] RATE_RESET = 4'h6;
  localparam logic [3:0] RATE_2PS = 4'h5;
  localparam logic [3:0] RATE_4PS = 4'h6;
  localparam logic [3:0] RATE_8PS = 4'h7;
  localparam logic [3:0] RATE_16PS = 4'h8;
  localparam logic [3:0] RATE_32PS = 4'h9;
  localparam logic [3:0] RATE_64PS = 4'hA;
  localparam logic [3:0] RATE_FALLBACK = 4'h4;

  // filter field codes
  localparam logic [1:0] FILTER_OFF = 2'h0;
  localparam logic [1:0] FILTER_L2 = 2'h3;
  localparam logic [1:0] FILTER_RESET = 2'h0;

  // data widths
  localparam int NUM_CH = 3;
  localparam int RESULT_W = 11;
  localparam int ACC_W = 15;
  localparam int HIST_OLD = 7;
  localparam logic [10:0] LIMIT_RESET = 11'h7FF;

  // timing: base tick is 1/64 s, the fastest conversion period
  localparam int CLK_PERIOD_NS = 10;
  localparam int RATE_TICK_NS = 15625000;
  localparam int RATE_TICK_CYCLES = RATE_TICK_NS / CLK_PERIOD_NS;
  localparam logic [10:0] SLOWEST_PERIOD_TICKS = 11'h400;

  typedef enum logic [2:0] {AVG_HALF, AVG_1X, AVG_2X, AVG_4X, AVG_8X, AVG_16X} avg_type;
  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} state_type;

  typedef struct packed {
    logic start;
    logic [1:0] channel;
    avg_type avg;
  } meas_req_type;

  typedef struct packed {
    logic done;
    logic [14:0] data;
  } meas_rsp_type;

endpackage

/* rtl/temp_sched.sv */
/*
  Conversion scheduler, dynamic averaging selection and running-average filter
  for a three-channel temperature sensor (channel 0 internal, 1 and 2 external).
  Assumes an analog front end that accepts one measurement request at a time and
  answers with an averaged accumulator; registers are reached over APB.

*/
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module temp_sched #(
  parameter int TICK_CYCLES = temp_sched_pkg::RATE_TICK_CYCLES
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // analog front end
  output temp_sched_pkg::meas_req_type MEAS_REQ,
  input wire temp_sched_pkg::meas_rsp_type MEAS_RSP,
  // status
  output logic [2:0] HIGH_FLAGS,
  output logic CONV_BUSY
);

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_data;
  logic addr_ok;
  logic setup_done;
  logic wr_en;
  logic [3:0] config_q;
  logic [3:0] rate_q;
  logic [1:0] filter_q;
  logic [10:0] limit_q [0:2];
  logic [10:0] result_q [0:2];
  logic [2:0] high_q;
  logic os_q;
  temp_sched_pkg::state_type state_q;
  logic [1:0] ch_q;
  temp_sched_pkg::avg_type cyc_avg_q;
  temp_sched_pkg::avg_type cur_avg;
  temp_sched_pkg::avg_type rate_avg;
  temp_sched_pkg::meas_req_type meas_req_q;
  logic busy_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [10:0] per_cnt_q;
  logic start_cycle;
  logic store_en;
  logic [2:0] shift;
  logic [14:0] acc_shifted;
  logic [10:0] raw11;
  logic [10:0] filt_val [1:2];
  logic filt_on [1:2];

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign MEAS_REQ = meas_req_q;
  assign HIGH_FLAGS = high_q;
  assign CONV_BUSY = busy_q;

  // apb: one wait state, answer comes one edge after the access phase opens
  assign setup_done = PSEL && PENABLE && !pready_q;
  assign wr_en = PSEL && PENABLE && pready_q && PWRITE && addr_ok;

  always_comb begin
    rd_data = 32'h0000_0000;
    addr_ok = 1'b1;
    unique case (PADDR)
      temp_sched_pkg::ADDR_CONFIG: rd_data = {28'h000_0000, config_q};
      temp_sched_pkg::ADDR_RATE: rd_data = {28'h000_0000, rate_q};
      temp_sched_pkg::ADDR_FILTER: rd_data = {30'h0000_0000, filter_q};
      temp_sched_pkg::ADDR_ONESHOT: rd_data = 32'h0000_0000;
      temp_sched_pkg::ADDR_STATUS: rd_data = {28'h000_0000, high_q, busy_q};
      default: begin
        addr_ok = 1'b0;
        for (int c = 0; c < temp_sched_pkg::NUM_CH; c++) begin
          if (PADDR == temp_sched_pkg::ADDR_RESULT_BASE + 12'(c) * temp_sched_pkg::REG_STRIDE) begin
            rd_data = {21'h00_0000, result_q[c]};
            addr_ok = 1'b1;
          end
          if (PADDR == temp_sched_pkg::ADDR_LIMIT_BASE + 12'(c) * temp_sched_pkg::REG_STRIDE) begin
            rd_data = {21'h00_0000, limit_q[c]};
            addr_ok = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup_done;
      pslverr_q <= setup_done && !addr_ok;
      if (setup_done && !PWRITE) begin
        prdata_q <= rd_data;
      end
    end
  end

  // software-written controls
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      config_q <= temp_sched_pkg::CONFIG_RESET;
      rate_q <= temp_sched_pkg::RATE_RESET;
      filter_q <= temp_sched_pkg::FILTER_RESET;
      for (int c = 0; c < temp_sched_pkg::NUM_CH; c++) begin
        limit_q[c] <= temp_sched_pkg::LIMIT_RESET;
      end
    end else if (wr_en) begin
      if (PADDR == temp_sched_pkg::ADDR_CONFIG) config_q <= PWDATA[3:0];
      if (PADDR == temp_sched_pkg::ADDR_RATE) rate_q <= PWDATA[3:0];
      if (PADDR == temp_sched_pkg::ADDR_FILTER) filter_q <= PWDATA[1:0];
      for (int c = 0; c < temp_sched_pkg::NUM_CH; c++) begin
        if (PADDR == temp_sched_pkg::ADDR_LIMIT_BASE + 12'(c) * temp_sched_pkg::REG_STRIDE) begin
          limit_q[c] <= PWDATA[10:0];
        end
      end
    end
  end

  // single-conversion request, honoured only in standby
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      os_q <= 1'b0;
    end else if (!config_q[temp_sched_pkg::CFG_STANDBY]) begin
      os_q <= 1'b0;
    end else if (wr_en && PADDR == temp_sched_pkg::ADDR_ONESHOT && state_q == temp_sched_pkg::S_IDLE) begin
      os_q <= 1'b1;
    end else if (start_cycle) begin
      os_q <= 1'b0;
    end
  end

  // base tick of 1/64 s from the system clock
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  function automatic logic [10:0] period_ticks(input logic [3:0] code);
    logic [3:0] eff;
    eff = (code > temp_sched_pkg::RATE_64PS) ? temp_sched_pkg::RATE_FALLBACK : code;
    return temp_sched_pkg::SLOWEST_PERIOD_TICKS >> eff;
  endfunction

  // period reloads only at cycle start, so a new code never cuts a cycle short
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      per_cnt_q <= 11'h000;
    end else if (config_q[temp_sched_pkg::CFG_STANDBY]) begin
      per_cnt_q <= 11'h000;
    end else if (start_cycle) begin
      per_cnt_q <= period_ticks(rate_q);
    end else if (tick && per_cnt_q != 11'h000) begin
      per_cnt_q <= per_cnt_q - 11'h001;
    end
  end

  // averaging factor that the current rate code asks for
  always_comb begin
    if (rate_q == temp_sched_pkg::RATE_64PS) begin
      rate_avg = temp_sched_pkg::AVG_HALF;
    end else if (config_q[temp_sched_pkg::CFG_DYNAVG_OFF]) begin
      rate_avg = temp_sched_pkg::AVG_1X;
    end else begin
      unique case (rate_q)
        temp_sched_pkg::RATE_4PS: rate_avg = temp_sched_pkg::AVG_8X;
        temp_sched_pkg::RATE_8PS: rate_avg = temp_sched_pkg::AVG_4X;
        temp_sched_pkg::RATE_16PS: rate_avg = temp_sched_pkg::AVG_2X;
        temp_sched_pkg::RATE_32PS: rate_avg = temp_sched_pkg::AVG_1X;
        default: rate_avg = temp_sched_pkg::AVG_16X;
      endcase
    end
  end

  // the internal channel is never stretched
  assign cur_avg = (ch_q == 2'h0) ? temp_sched_pkg::AVG_1X : cyc_avg_q;
  assign start_cycle = (state_q == temp_sched_pkg::S_IDLE) &&
                       (config_q[temp_sched_pkg::CFG_STANDBY] ? os_q : per_cnt_q == 11'h000);
  assign store_en = (state_q == temp_sched_pkg::S_WAIT) && MEAS_RSP.done;

  // sequencer: one request per channel, wait for its answer
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      state_q <= temp_sched_pkg::S_IDLE;
      ch_q <= 2'h0;
      cyc_avg_q <= temp_sched_pkg::AVG_8X;
      busy_q <= 1'b0;
      meas_req_q <= '0;
    end else begin
      meas_req_q.start <= 1'b0;
      unique case (state_q)
        temp_sched_pkg::S_IDLE: begin
          if (start_cycle) begin
            cyc_avg_q <= rate_avg;
            ch_q <= 2'h0;
            busy_q <= 1'b1;
            state_q <= temp_sched_pkg::S_ISSUE;
          end
        end
        temp_sched_pkg::S_ISSUE: begin
          meas_req_q.start <= 1'b1;
          meas_req_q.channel <= ch_q;
          meas_req_q.avg <= cur_avg;
          state_q <= temp_sched_pkg::S_WAIT;
        end
        temp_sched_pkg::S_WAIT: begin
          if (MEAS_RSP.done) begin
            if (ch_q == 2'(temp_sched_pkg::NUM_CH - 1)) begin
              busy_q <= 1'b0;
              state_q <= temp_sched_pkg::S_IDLE;
            end else begin
              ch_q <= ch_q + 2'h1;
              state_q <= temp_sched_pkg::S_ISSUE;
            end
          end
        end
        default: state_q <= temp_sched_pkg::S_IDLE;
      endcase
    end
  end

  // pick the 11 result bits out of the stretched accumulator
  assign shift = (cur_avg == temp_sched_pkg::AVG_HALF) ? 3'h0 : 3'(cur_avg) - 3'h1;
  assign acc_shifted = MEAS_RSP.data >> shift;
  assign raw11 = acc_shifted[10:0];

  for (genvar c = 1; c <= 2; c++) begin : g_flt
    logic [10:0] hist_q [0:temp_sched_pkg::HIST_OLD-1];
    logic primed_q;
    logic [13:0] sum8;
    logic [12:0] sum4;

    always_comb begin
      sum8 = 14'(raw11);
      sum4 = 13'(raw11);
      for (int i = 0; i < temp_sched_pkg::HIST_OLD; i++) begin
        sum8 = sum8 + 14'(hist_q[i]);
        if (i < 3) sum4 = sum4 + 13'(hist_q[i]);
      end
    end

    // fraction bits dropped: a slow drift may read up to one lsb low
    assign filt_val[c] = !primed_q ? raw11 :
                         (filter_q == temp_sched_pkg::FILTER_L2) ? sum8[13:3] : sum4[12:2];
    assign filt_on[c] = (filter_q != temp_sched_pkg::FILTER_OFF) &&
                        !config_q[temp_sched_pkg::CFG_PAIRED1 + c - 1];

    // history runs even with the filter off, so enabling it later starts clean
    always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
        primed_q <= 1'b0;
        for (int i = 0; i < temp_sched_pkg::HIST_OLD; i++) hist_q[i] <= 11'h000;
      end else if (store_en && ch_q == 2'(c)) begin
        primed_q <= 1'b1;
        hist_q[0] <= raw11;
        for (int i = 1; i < temp_sched_pkg::HIST_OLD; i++) begin
          hist_q[i] <= !primed_q ? raw11 : hist_q[i-1];
        end
      end
    end
  end

  // result store and limit check at the end of each channel's conversion
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      high_q <= 3'h0;
      for (int c = 0; c < temp_sched_pkg::NUM_CH; c++) result_q[c] <= 11'h000;
    end else if (store_en) begin
      if (ch_q == 2'h0) begin
        result_q[0] <= raw11;
        high_q[0] <= raw11 > limit_q[0];
      end
      for (int c = 1; c <= 2; c++) begin
        if (ch_q == 2'(c)) begin
          result_q[c] <= filt_on[c] ? filt_val[c] : raw11;
          high_q[c] <= (filt_on[c] ? filt_val[c] : raw11) > limit_q[c];
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  logic [12:0] chk_sum4;
  assign chk_sum4 = 13'(g_flt[1].hist_q[0]) + 13'(g_flt[1].hist_q[1]) +
                    13'(g_flt[1].hist_q[2]) + 13'(g_flt[1].hist_q[3]);

  property p_oneshot_ignored;
    wr_en && PADDR == temp_sched_pkg::ADDR_ONESHOT && !config_q[temp_sched_pkg::CFG_STANDBY]
      |=> !os_q;
  endproperty
  a_oneshot_ignored: assert property (p_oneshot_ignored) else $error("single request taken while active");

  property p_standby_quiet;
    config_q[temp_sched_pkg::CFG_STANDBY] && state_q == temp_sched_pkg::S_IDLE && !os_q
      |=> state_q == temp_sched_pkg::S_IDLE;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("standby converted unasked");

  property p_rate_reset;
    !$past(NRST) |-> rate_q == temp_sched_pkg::RATE_RESET;
  endproperty
  a_rate_reset: assert property (p_rate_reset) else $error("rate code reset wrong");

  property p_avg_4ps;
    start_cycle && rate_q == temp_sched_pkg::RATE_4PS && !config_q[temp_sched_pkg::CFG_DYNAVG_OFF]
      |=> cyc_avg_q == temp_sched_pkg::AVG_8X ##1 meas_req_q.avg == temp_sched_pkg::AVG_1X;
  endproperty
  a_avg_4ps: assert property (p_avg_4ps) else $error("averaging factor wrong at 4 per second");

  property p_avg_off;
    start_cycle && config_q[temp_sched_pkg::CFG_DYNAVG_OFF] && rate_q != temp_sched_pkg::RATE_64PS
      |=> cyc_avg_q == temp_sched_pkg::AVG_1X;
  endproperty
  a_avg_off: assert property (p_avg_off) else $error("averaging not off");

  property p_avg_held;
    state_q == temp_sched_pkg::S_WAIT |-> $stable(cyc_avg_q);
  endproperty
  a_avg_held: assert property (p_avg_held) else $error("factor changed mid cycle");

  property p_timer_due;
    !config_q[temp_sched_pkg::CFG_STANDBY] && state_q == temp_sched_pkg::S_IDLE && per_cnt_q == 11'h000
      |=> state_q == temp_sched_pkg::S_ISSUE ##1 meas_req_q.start && meas_req_q.channel == 2'h0;
  endproperty
  a_timer_due: assert property (p_timer_due) else $error("due cycle not started");

  property p_first_fill;
    store_en && ch_q == 2'h1 && !g_flt[1].primed_q
      |=> g_flt[1].hist_q[6] == $past(raw11) && result_q[1] == $past(raw11);
  endproperty
  a_first_fill: assert property (p_first_fill) else $error("history not filled on first sample");

  property p_level1;
    store_en && ch_q == 2'h1 && g_flt[1].primed_q && filter_q == 2'h1 && !config_q[temp_sched_pkg::CFG_PAIRED1]
      |=> result_q[1] == chk_sum4[12:2];
  endproperty
  a_level1: assert property (p_level1) else $error("level 1 average wrong");

  property p_paired_bypass;
    store_en && ch_q == 2'h2 && config_q[temp_sched_pkg::CFG_PAIRED2] |=> result_q[2] == $past(raw11);
  endproperty
  a_paired_bypass: assert property (p_paired_bypass) else $error("filter applied in paired mode");

  property p_limit_filtered;
    store_en ##1 1'b1 |-> high_q[$past(ch_q)] == (result_q[$past(ch_q)] > limit_q[$past(ch_q)]);
  endproperty
  a_limit_filtered: assert property (p_limit_filtered) else $error("limit flag not from stored result");

  c_oneshot: cover property (config_q[temp_sched_pkg::CFG_STANDBY] && start_cycle ##[1:300] !busy_q);
  c_level2: cover property (store_en && ch_q == 2'h1 && filter_q == temp_sched_pkg::FILTER_L2);
  c_fast: cover property (start_cycle && rate_q == temp_sched_pkg::RATE_64PS);

endmodule

/* dv/afe_model.sv */
/*
  Behavioural analog front end that answers the scheduler's measurement requests.
  Assumes one request at a time, a bench-set per-channel value and a bench-set answer delay.
*/
`timescale 1ns/1ps
module afe_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // scheduler side
  input wire temp_sched_pkg::meas_req_type req,
  output temp_sched_pkg::meas_rsp_type rsp,
  // bench control
  input wire logic [2:0][14:0] ch_data,
  input wire logic [7:0] delay
);
  logic busy_q;
  logic [7:0] cnt_q;
  logic [1:0] ch_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      ch_q <= 2'h0;
      rsp <= '0;
    end else begin
      rsp.done <= 1'b0;
      // data outside an answer toggles so a stale value is never mistaken for a result
      rsp.data <= ~rsp.data;
      if (req.start) begin
        busy_q <= 1'b1;
        cnt_q <= delay;
        ch_q <= req.channel;
      end else if (busy_q && cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        rsp.done <= 1'b1;
        rsp.data <= ch_data[ch_q];
      end
    end
  end
endmodule

/* dv/testbench.sv */
/*
  Self-checking bench for the conversion scheduler and result filter.
  Assumes afe_model as the front end and a rate tick shortened to ten clocks.
*/
`timescale 1ns/1ps
module testbench;
  localparam int TICK = 10;
  localparam logic [11:0] RES1 = 12'h018;
  localparam logic [11:0] LIM1 = 12'h024;
  typedef struct {
    logic [3:0] rate;
    logic off;
    logic [2:0] avg;
  } row_type;

  logic sys_clk;
  logic nrst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  temp_sched_pkg::meas_req_type meas_req;
  temp_sched_pkg::meas_rsp_type meas_rsp;
  logic [2:0] high_flags;
  logic conv_busy;
  logic [2:0][14:0] ch_data;
  logic [7:0] afe_delay;
  int num_errors;
  int total_checks;
  int n;
  int m4, m7, m8, mb;
  logic [10:0] hist [8];
  logic hist_full;
  logic [31:0] rd;
  logic er;
  logic [10:0] exp_v;
  logic [10:0] lim1;
  row_type rows [12];
  logic [1:0] fcode [6];
  logic [10:0] fdata [6];

  temp_sched #(.TICK_CYCLES(TICK)) temp_sched_inst (
    .SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MEAS_REQ(meas_req), .MEAS_RSP(meas_rsp), .HIGH_FLAGS(high_flags), .CONV_BUSY(conv_busy)
  );

  afe_model afe_model_inst (
    .clk(sys_clk), .nrst(nrst), .req(meas_req), .rsp(meas_rsp), .ch_data(ch_data), .delay(afe_delay)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [10:0] raw1(input logic [14:0] d, input logic [2:0] a);
    logic [14:0] s;
    s = (a > 3'h1) ? d >> (a - 3'h1) : d;
    return s[10:0];
  endfunction

  // expected stored value if raw arrives now, from the mirrored history
  function automatic logic [10:0] predict(input logic [1:0] code, input logic [10:0] raw);
    logic [13:0] sum;
    sum = {3'h0, raw};
    for (int i = 0; i < 7; i++) begin
      if (code == 2'h3 || i < 3) sum = sum + {3'h0, hist[i]};
    end
    if (code == 2'h0) return raw;
    return (code == 2'h3) ? sum[13:3] : sum[12:2];
  endfunction

  // mirror of every channel 1 answer; the first one fills all slots
  always @(posedge sys_clk) begin
    if (meas_rsp.done === 1'b1 && meas_req.channel === 2'h1) begin
      for (int i = 7; i > 0; i--) begin
        hist[i] = hist_full ? hist[i - 1] : raw1(meas_rsp.data, meas_req.avg);
      end
      hist[0] = raw1(meas_rsp.data, meas_req.avg);
      hist_full = 1'b1;
    end
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic fail_wait(input string what);
    num_errors++;
    $display("Error at %0t: no %s", $time, what);
    complete_run();
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) fail_wait("apb ready");
  endtask

  task automatic wait_busy(input logic lvl);
    n = 0;
    while (conv_busy !== lvl && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) fail_wait("busy change");
  endtask

  task automatic wait_req(input logic [1:0] ch);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!(meas_req.start === 1'b1 && meas_req.channel === ch) && n < 20000);
    if (n >= 20000) fail_wait("measure request");
  endtask

  task automatic convert_once;
    apb(1'b1, temp_sched_pkg::ADDR_ONESHOT, 32'h0000_0001);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask

  task automatic quiet(input string what);
    n = 0;
    repeat (300) begin
      @(posedge sys_clk);
      if (conv_busy !== 1'b0) n++;
    end
    check(n, 0, what);
  endtask

  task automatic measure(input logic [3:0] code, output int cyc);
    apb(1'b1, temp_sched_pkg::ADDR_RATE, {28'h0, code});
    wait_req(2'h0);
    wait_req(2'h0);
    wait_req(2'h0);
    cyc = n;
  endtask

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ch_data = {15'h1234, 15'h5a5a, 15'h0123};
    afe_delay = 8'hc8;
    num_errors = 0;
    total_checks = 0;
    hist_full = 1'b0;
    lim1 = temp_sched_pkg::LIMIT_RESET;
    rows = '{'{4'h0, 1'b0, 3'h5}, '{4'h3, 1'b0, 3'h5}, '{4'h5, 1'b0, 3'h5}, '{4'h6, 1'b0, 3'h4},
      '{4'h7, 1'b0, 3'h3}, '{4'h8, 1'b0, 3'h2}, '{4'h9, 1'b0, 3'h1}, '{4'ha, 1'b0, 3'h0},
      '{4'hc, 1'b0, 3'h5}, '{4'h6, 1'b1, 3'h1}, '{4'ha, 1'b1, 3'h0}, '{4'h0, 1'b1, 3'h1}};
    fcode = '{2'h3, 2'h1, 2'h2, 2'h3, 2'h0, 2'h3};
    fdata = '{11'h100, 11'h600, 11'h100, 11'h600, 11'h100, 11'h7ff};
    repeat (20) @(posedge sys_clk);
    check({29'h0, conv_busy, meas_req.start, pready}, 32'h0000_0000, "outputs in reset");
    nrst <= 1'b1;
    wait_req(2'h0);
    check({31'h0, n <= 4}, 32'h0000_0001, "first start late");
    for (int a = 0; a < 11; a++) begin
      if (a != 4) begin
        apb(1'b0, 12'(a * 4), 32'h0000_0000);
        check(rd, a == 1 ? 32'h0000_0006 : (a > 7 ? {21'h0, temp_sched_pkg::LIMIT_RESET} : 32'h0), "reset");
      end
    end
    apb(1'b1, 12'h040, 32'h0000_0001);
    check({31'h0, er}, 32'h0000_0001, "unmapped write");
    afe_delay <= 8'h03;
    apb(1'b1, temp_sched_pkg::ADDR_CONFIG, 32'h0000_0001);
    wait_busy(1'b0);
    apb(1'b1, RES1, 32'h0000_07ff);
    apb(1'b0, RES1, 32'h0000_0000);
    check(rd, {21'h0, raw1(15'h5a5a, 3'h4)}, "first result");
    foreach (rows[i]) begin
      apb(1'b1, temp_sched_pkg::ADDR_CONFIG, {30'h0, rows[i].off, 1'b1});
      apb(1'b1, temp_sched_pkg::ADDR_RATE, {28'h0, rows[i].rate});
      apb(1'b1, temp_sched_pkg::ADDR_ONESHOT, 32'h0000_0001);
      wait_req(2'h1);
      check({29'h0, meas_req.avg}, {29'h0, rows[i].avg}, "averaging");
      wait_busy(1'b0);
      apb(1'b0, RES1, 32'h0000_0000);
      check(rd, {21'h0, raw1(15'h5a5a, rows[i].avg)}, "raw result");
    end
    quiet("standby conversion");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, temp_sched_pkg::ADDR_FILTER, {30'h0, fcode[i]});
      ch_data[1] <= {4'h0, fdata[i]};
      exp_v = predict(fcode[i], fdata[i]);
      // limit between raw and filtered, so only the filtered value keeps the flag low
      if (i == 5) lim1 = 11'(({1'b0, exp_v} + {1'b0, fdata[i]}) >> 1);
      apb(1'b1, LIM1, {21'h0, lim1});
      convert_once();
      apb(1'b0, RES1, 32'h0000_0000);
      check(rd, {21'h0, exp_v}, "filtered result");
      check({31'h0, high_flags[1]}, {31'h0, exp_v > lim1}, "high flag");
    end
    apb(1'b0, temp_sched_pkg::ADDR_RESULT_BASE, 32'h0000_0000);
    check(rd, 32'h0000_0123, "internal channel");
    // both channels paired, averaging off so the raw value is the stored one
    apb(1'b1, temp_sched_pkg::ADDR_CONFIG, 32'h0000_000f);
    apb(1'b1, 12'h028, 32'h0000_0233);
    ch_data[1] <= 15'h0200;
    convert_once();
    apb(1'b0, RES1, 32'h0000_0000);
    check(rd, 32'h0000_0200, "paired bypass");
    apb(1'b0, 12'h01c, 32'h0000_0000);
    check(rd, 32'h0000_0234, "paired bypass ch2");
    apb(1'b0, temp_sched_pkg::ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0008, "status flags");
    check({29'h0, high_flags}, 32'h0000_0004, "high flags");
    afe_delay <= 8'h01;
    apb(1'b1, temp_sched_pkg::ADDR_CONFIG, 32'h0000_0000);
    measure(4'h4, m4);
    measure(4'h7, m7);
    measure(4'h8, m8);
    measure(4'hb, mb);
    check(mb, m4, "fallback rate");
    check(m7 - m8, 4 * TICK, "rate step");
    check(m4 - m7, 56 * TICK, "rate span");
    wait_busy(1'b0);
    apb(1'b1, temp_sched_pkg::ADDR_ONESHOT, 32'h0000_0001);
    quiet("active one-shot");
    complete_run();
  end
endmodule
